// ===== hw/spc_core.sv
// Purpose: Alert merging, pin control, pin overrides and over-current
//          sequencing behind an APB slave.
// Assumes: Pins and comparator inputs are asynchronous; ext_flags are
//          levels from modules on pclk.
// Notes: Zero-wait APB; pready rises in the first access cycle.
// Function
// - Single open-drain active-low alert from flags
// - Top flags follow sources; writes ignored
// - Pin, override, change flags write-one-clear
// - Sixteen pins, each with own config
// - Level vector read shows pin states
// - Each pin may raise pin event
// - Output vector and drive bits stay consistent
// - Commit copies the per-pin shadows in one cycle; output shadow not copied
// - Per-pin shadow drive wins on mismatch
// - Commit request clears itself when applied
// - Pending override blocks and holds commit
// - Four overrides with selectable sources
// - Watch match forces masked pins two clocks later
// - Own mask per override, overlaps allowed
// - Override firing sets override event flag
// - Debounced event sets change and top flag
// - Level bit follows rising and falling
// - Control bit gates comparison; sources selectable
// - Sense inputs usable as override source
`timescale 1ns/1ps
`default_nettype none
module spc_core
  import spc_pkg::*;
#(
  parameter int PIN_N = PIN_COUNT,
  parameter int EXT_W = EXT_COUNT
)
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt levels from other modules.
  input wire logic [EXT_W-1:0] ext_flags,
  // Programmable pins.
  input wire logic [PIN_N-1:0] pin_in,
  output logic [PIN_N-1:0] pin_out,
  output logic [PIN_N-1:0] pin_oe,
  // Over-current comparator.
  input wire logic overcurrent_sense_a,
  input wire logic overcurrent_sense_b,
  output logic [THR_W-1:0] overcurrent_threshold_a,
  output logic [THR_W-1:0] overcurrent_threshold_b,
  output logic overcurrent_compare_on,
  // Open-drain alert, active low.
  output logic alert_n_out,
  output logic alert_n_oe
);

  localparam int TOP_W = TOP_EXT + EXT_W;
  localparam int SV_W = PIN_N + 2;

  // ==========================================================
  // Registers
  logic pready_r, pslverr_r;
  logic [31:0] prdata_r;
  logic [TOP_W-1:0] top_event_flags_r, top_enable_r;
  logic [PIN_N-1:0] pin_s1_r, pin_s2_r, pin_prev_r;
  logic [PIN_N-1:0] pin_event_flags_r, pin_output_vector_r;
  logic [PIN_N-1:0] oe_cfg_r, ev_en_r, ev_rise_r;
  logic [PIN_N-1:0] sh_drive_r, sh_oe_r, sh_ev_en_r, sh_ev_rise_r;
  logic [PIN_N-1:0] pin_output_shadow_r, pin_out_r, pin_oe_r;
  logic shadow_commit_request_r;
  logic [OVR_COUNT-1:0] override_arm_r, override_watch_value_r;
  logic [OVR_COUNT-1:0] pending_r, override_event_flags_r;
  logic [SRC_W-1:0] src_sel_r [OVR_COUNT];
  logic [PIN_N-1:0] ovr_mask_r [OVR_COUNT];
  logic [PIN_N-1:0] ovr_state_r [OVR_COUNT];
  logic overcurrent_control_r;
  logic [THR_W-1:0] thr_a_r, thr_b_r;
  logic [DEB_W-1:0] overcurrent_debounce_time_r;
  logic [1:0] overcurrent_input_enable_r, overcurrent_change_flags_r;
  logic alert_n_oe_r, alert_n_out_r;

  // Combinational nets.
  logic setup, wr, hit, cfg_hit, sh_hit, mask_hit, commit_go;
  logic [31:0] rd_data;
  logic [3:0] ci;
  logic [1:0] mi;
  logic [1:0] oc_level, oc_chg, oc_run;
  logic [SV_W-1:0] src_vec;
  logic [OVR_COUNT-1:0] fire;
  logic [PIN_N-1:0] pin_ev, drive_nxt, oe_nxt;

  // ==========================================================
  // APB slave
  assign setup = psel & ~penable;
  assign wr = psel & penable & pwrite & pready_r;
  assign ci = paddr[5:2];
  assign mi = paddr[3:2];
  assign cfg_hit = (paddr[11:6] == A_CFG[11:6]) && (32'(ci) < PIN_N);
  assign sh_hit = (paddr[11:6] == A_CFG_SH[11:6]) && (32'(ci) < PIN_N);
  assign mask_hit = paddr[11:4] == A_OVR_MASK[11:4];

  // Read mux; the reads have no side effects.
  always_comb
  begin
    rd_data = '0;
    hit = 1'b1;
    unique case (paddr)
      A_TOP_FLAGS: rd_data = 32'(top_event_flags_r);
      A_TOP_ENABLE: rd_data = 32'(top_enable_r);
      A_PIN_LEVEL: rd_data = 32'(pin_s2_r);
      A_PIN_FLAGS: rd_data = 32'(pin_event_flags_r);
      A_PIN_VEC: rd_data = 32'(pin_output_vector_r);
      A_PIN_VEC_SH: rd_data = 32'(pin_output_shadow_r);
      A_COMMIT: rd_data = 32'(shadow_commit_request_r);
      A_OVR_ARM: rd_data = 32'(override_arm_r);
      A_OVR_WATCH: rd_data = 32'(override_watch_value_r);
      A_OVR_FLAGS: rd_data = 32'(override_event_flags_r);
      A_OVR_SRC: for (int i = 0; i < OVR_COUNT; i++)
        rd_data[i*SRC_FIELD +: SRC_W] = src_sel_r[i];
      A_OC_CTRL: rd_data = 32'({|oc_run, overcurrent_control_r});
      A_OC_THR: rd_data = 32'({thr_b_r, thr_a_r});
      A_OC_DEB: rd_data = 32'(overcurrent_debounce_time_r);
      A_OC_INEN: rd_data = 32'(overcurrent_input_enable_r);
      A_OC_LEVEL: rd_data = 32'(oc_level);
      A_OC_CHG: rd_data = 32'(overcurrent_change_flags_r);
      default:
      begin
        if (cfg_hit)
          rd_data = 32'({ev_rise_r[ci], ev_en_r[ci], oe_cfg_r[ci],
                         pin_output_vector_r[ci]});
        else if (sh_hit)
          rd_data = 32'({sh_ev_rise_r[ci], sh_ev_en_r[ci], sh_oe_r[ci],
                         sh_drive_r[ci]});
        else if (mask_hit)
          rd_data = {ovr_state_r[mi], ovr_mask_r[mi]};
        else
          hit = 1'b0;
      end
    endcase
  end

  // Data and status are captured in setup and shown in the access cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end
    else
    begin
      pready_r <= setup;
      pslverr_r <= setup & ~hit;
      prdata_r <= (setup && !pwrite && hit) ? rd_data : '0;
    end
  end

  // ==========================================================
  // Pin sampling and pin events
  // The first flop feeds only the second one.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      pin_prev_r <= '0;
    end
    else
    begin
      pin_s1_r <= pin_in;
      pin_s2_r <= pin_s1_r;
      pin_prev_r <= pin_s2_r;
    end
  end

  // Enabled pins flag the chosen edge.
  assign pin_ev = ev_en_r & ((ev_rise_r & pin_s2_r & ~pin_prev_r)
                  | (~ev_rise_r & ~pin_s2_r & pin_prev_r));

  // A new event beats a clear written in the same cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pin_event_flags_r <= '0;
    else if (wr && paddr == A_PIN_FLAGS)
      pin_event_flags_r <= (pin_event_flags_r & ~pwdata[PIN_N-1:0]) | pin_ev;
    else
      pin_event_flags_r <= pin_event_flags_r | pin_ev;
  end

  // ==========================================================
  // Live and shadow pin configuration
  assign commit_go = shadow_commit_request_r & ~|pending_r;

  // The drive bit has one home, so both views always agree.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_output_vector_r <= '0;
      oe_cfg_r <= '0;
      ev_en_r <= '0;
      ev_rise_r <= '0;
    end
    else if (commit_go)
    begin
      pin_output_vector_r <= sh_drive_r;
      oe_cfg_r <= sh_oe_r;
      ev_en_r <= sh_ev_en_r;
      ev_rise_r <= sh_ev_rise_r;
    end
    else if (wr && paddr == A_PIN_VEC)
      pin_output_vector_r <= pwdata[PIN_N-1:0];
    else if (wr && cfg_hit)
    begin
      pin_output_vector_r[ci] <= pwdata[CFG_DRIVE];
      oe_cfg_r[ci] <= pwdata[CFG_OE];
      ev_en_r[ci] <= pwdata[CFG_EV_EN];
      ev_rise_r[ci] <= pwdata[CFG_EV_RISE];
    end
  end

  // Shadow copies; the output shadow is kept for readback only.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sh_drive_r <= '0;
      sh_oe_r <= '0;
      sh_ev_en_r <= '0;
      sh_ev_rise_r <= '0;
      pin_output_shadow_r <= '0;
    end
    else if (wr && sh_hit)
    begin
      sh_drive_r[ci] <= pwdata[CFG_DRIVE];
      sh_oe_r[ci] <= pwdata[CFG_OE];
      sh_ev_en_r[ci] <= pwdata[CFG_EV_EN];
      sh_ev_rise_r[ci] <= pwdata[CFG_EV_RISE];
    end
    else if (wr && paddr == A_PIN_VEC_SH)
      pin_output_shadow_r <= pwdata[PIN_N-1:0];
  end

  // A request written while one is applied survives.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      shadow_commit_request_r <= 1'b0;
    else if (wr && paddr == A_COMMIT && pwdata[COMMIT_REQ])
      shadow_commit_request_r <= 1'b1;
    else if (commit_go)
      shadow_commit_request_r <= 1'b0;
  end

  // ==========================================================
  // Overrides
  assign src_vec = {oc_level, pin_s2_r};

  // Sources past the last comparator never fire.
  always_comb
  begin
    fire = '0;
    for (int i = 0; i < OVR_COUNT; i++)
      if (32'(src_sel_r[i]) < SV_W)
        fire[i] = override_arm_r[i] & ~pending_r[i]
                  & (src_vec[src_sel_r[i]] == override_watch_value_r[i]);
  end

  // Override setup registers.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      override_arm_r <= '0;
      override_watch_value_r <= '0;
      for (int i = 0; i < OVR_COUNT; i++)
      begin
        src_sel_r[i] <= '0;
        ovr_mask_r[i] <= '0;
        ovr_state_r[i] <= '0;
      end
    end
    else if (wr)
    begin
      if (paddr == A_OVR_ARM)
        override_arm_r <= pwdata[OVR_COUNT-1:0];
      if (paddr == A_OVR_WATCH)
        override_watch_value_r <= pwdata[OVR_COUNT-1:0];
      if (paddr == A_OVR_SRC)
        for (int i = 0; i < OVR_COUNT; i++)
          src_sel_r[i] <= pwdata[i*SRC_FIELD +: SRC_W];
      if (mask_hit)
      begin
        ovr_mask_r[mi] <= pwdata[PIN_N-1:0];
        ovr_state_r[mi] <= pwdata[OVR_STATE_LSB +: PIN_N];
      end
    end
  end

  // Disarming an override is the only way to drop its pending state.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pending_r <= '0;
      override_event_flags_r <= '0;
    end
    else
    begin
      if (wr && paddr == A_OVR_ARM)
        pending_r <= (pending_r & pwdata[OVR_COUNT-1:0]) | fire;
      else
        pending_r <= pending_r | fire;
      if (wr && paddr == A_OVR_FLAGS)
        override_event_flags_r <= (override_event_flags_r
          & ~pwdata[OVR_COUNT-1:0]) | fire;
      else
        override_event_flags_r <= override_event_flags_r | fire;
    end
  end

  // Later overrides win where masks overlap.
  always_comb
  begin
    drive_nxt = pin_output_vector_r;
    oe_nxt = oe_cfg_r;
    for (int i = 0; i < OVR_COUNT; i++)
      if (pending_r[i])
      begin
        drive_nxt = (drive_nxt & ~ovr_mask_r[i]) | (ovr_state_r[i] & ovr_mask_r[i]);
        oe_nxt = oe_nxt | ovr_mask_r[i];
      end
  end

  // Pin drivers.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_out_r <= '0;
      pin_oe_r <= '0;
    end
    else
    begin
      pin_out_r <= drive_nxt;
      pin_oe_r <= oe_nxt;
    end
  end

  // ==========================================================
  // Over-current sequencing
  // Filters stop as soon as the control bit drops.
  spc_ocs_filter #(.DW(DEB_W)) u_filt_a (
    .pclk(pclk), .presetn(presetn), .sense_in(overcurrent_sense_a),
    .enable(overcurrent_control_r & overcurrent_input_enable_r[0]),
    .deb_cycles(overcurrent_debounce_time_r),
    .level_r(oc_level[0]), .changed_r(oc_chg[0]), .running_r(oc_run[0]));
  spc_ocs_filter #(.DW(DEB_W)) u_filt_b (
    .pclk(pclk), .presetn(presetn), .sense_in(overcurrent_sense_b),
    .enable(overcurrent_control_r & overcurrent_input_enable_r[1]),
    .deb_cycles(overcurrent_debounce_time_r),
    .level_r(oc_level[1]), .changed_r(oc_chg[1]), .running_r(oc_run[1]));

  // Comparator setup; software changes it only while stopped.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      overcurrent_control_r <= 1'b0;
      thr_a_r <= RST_THR;
      thr_b_r <= RST_THR;
      overcurrent_debounce_time_r <= RST_DEB;
      overcurrent_input_enable_r <= '0;
    end
    else if (wr)
    begin
      if (paddr == A_OC_CTRL)
        overcurrent_control_r <= pwdata[OC_CTRL_ON];
      if (paddr == A_OC_THR)
      begin
        thr_a_r <= pwdata[THR_W-1:0];
        thr_b_r <= pwdata[THR_B_LSB +: THR_W];
      end
      if (paddr == A_OC_DEB)
        overcurrent_debounce_time_r <= pwdata[DEB_W-1:0];
      if (paddr == A_OC_INEN)
        overcurrent_input_enable_r <= pwdata[1:0];
    end
  end

  // Change flags; a new change beats the clear.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      overcurrent_change_flags_r <= '0;
    else if (wr && paddr == A_OC_CHG)
      overcurrent_change_flags_r <= (overcurrent_change_flags_r & ~pwdata[1:0])
                                    | oc_chg;
    else
      overcurrent_change_flags_r <= overcurrent_change_flags_r | oc_chg;
  end

  // ==========================================================
  // Top flags and alert
  // Top flags mirror their sources; writes to them do nothing.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      top_event_flags_r <= '0;
      top_enable_r <= '0;
    end
    else
    begin
      top_event_flags_r <= {ext_flags, |overcurrent_change_flags_r,
                            |override_event_flags_r, |pin_event_flags_r};
      if (wr && paddr == A_TOP_ENABLE)
        top_enable_r <= pwdata[TOP_W-1:0];
    end
  end

  // The pin is only ever pulled low; release lets it float high.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      alert_n_oe_r <= 1'b0;
      alert_n_out_r <= 1'b0;
    end
    else
    begin
      alert_n_oe_r <= |(top_event_flags_r & top_enable_r);
      alert_n_out_r <= 1'b0;
    end
  end

  // ==========================================================
  // Outputs
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign pin_out = pin_out_r;
  assign pin_oe = pin_oe_r;
  assign overcurrent_threshold_a = thr_a_r;
  assign overcurrent_threshold_b = thr_b_r;
  assign overcurrent_compare_on = overcurrent_control_r;
  assign alert_n_out = alert_n_out_r;
  assign alert_n_oe = alert_n_oe_r;

  // ==========================================================
  // Checks
  a_alert_follow: assert property (
    @(posedge pclk) disable iff (!presetn)
    ##1 alert_n_oe == $past(|(top_event_flags_r & top_enable_r)))
    else $error("Alert does not follow enabled flags.");

  a_top_no_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr && paddr == A_TOP_FLAGS && ext_flags[0]) |=> top_event_flags_r[TOP_EXT])
    else $error("Top flag cleared by a write.");

  a_pin_flag_w1c: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr && paddr == A_PIN_FLAGS)
    |=> (pin_event_flags_r & $past(pwdata[PIN_N-1:0] & ~pin_ev)) == '0)
    else $error("Pin flag not cleared by one.");

  a_commit_copy: assert property (
    @(posedge pclk) disable iff (!presetn)
    commit_go |=> (oe_cfg_r == $past(sh_oe_r))
                  && (pin_output_vector_r == $past(sh_drive_r)))
    else $error("Commit did not copy the shadow.");

  a_commit_self_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    (commit_go && !(wr && paddr == A_COMMIT)) |=> !shadow_commit_request_r)
    else $error("Commit request not cleared.");

  a_commit_blocked: assert property (
    @(posedge pclk) disable iff (!presetn)
    (shadow_commit_request_r && |pending_r) |=> shadow_commit_request_r
      && $stable(oe_cfg_r))
    else $error("Commit applied while override pending.");

  a_override_drive: assert property (
    @(posedge pclk) disable iff (!presetn)
    pending_r[0] |=> ((pin_oe & $past(ovr_mask_r[0])) == $past(ovr_mask_r[0])))
    else $error("Override did not enable its pins.");

  a_override_flag: assert property (
    @(posedge pclk) disable iff (!presetn)
    fire[0] |=> override_event_flags_r[0] ##1 top_event_flags_r[TOP_OVR])
    else $error("Override firing not flagged.");

  a_oc_change: assert property (
    @(posedge pclk) disable iff (!presetn)
    oc_chg[0] |=> overcurrent_change_flags_r[0] ##1 top_event_flags_r[TOP_OC])
    else $error("Over-current change not flagged.");

endmodule // spc_core
`default_nettype wire

// ===== hw/spc_pkg.sv
// Purpose: Shared constants of the system pin and alert controller.
// Assumes: APB register map, 32-bit data, one word per register.
// Notes: Offsets are byte addresses; field positions are bit indices.
package spc_pkg;

  // ==========================================================
  // Sizes
  localparam int PIN_COUNT = 16;
  localparam int OVR_COUNT = 4;
  localparam int EXT_COUNT = 9;
  localparam int SRC_W = 5;
  localparam int DEB_W = 16;
  localparam int THR_W = 8;
  localparam int ADDR_W = 12;

  // ==========================================================
  // Register offsets
  localparam logic [11:0] A_TOP_FLAGS = 12'h000;
  localparam logic [11:0] A_TOP_ENABLE = 12'h004;
  localparam logic [11:0] A_PIN_LEVEL = 12'h008;
  localparam logic [11:0] A_PIN_FLAGS = 12'h00c;
  localparam logic [11:0] A_PIN_VEC = 12'h010;
  localparam logic [11:0] A_PIN_VEC_SH = 12'h014;
  localparam logic [11:0] A_COMMIT = 12'h018;
  localparam logic [11:0] A_OVR_ARM = 12'h01c;
  localparam logic [11:0] A_OVR_WATCH = 12'h020;
  localparam logic [11:0] A_OVR_FLAGS = 12'h024;
  localparam logic [11:0] A_OVR_SRC = 12'h028;
  localparam logic [11:0] A_OC_CTRL = 12'h02c;
  localparam logic [11:0] A_OC_THR = 12'h030;
  localparam logic [11:0] A_OC_DEB = 12'h034;
  localparam logic [11:0] A_OC_INEN = 12'h038;
  localparam logic [11:0] A_OC_LEVEL = 12'h03c;
  localparam logic [11:0] A_OC_CHG = 12'h040;
  localparam logic [11:0] A_OVR_MASK = 12'h050;
  localparam logic [11:0] A_CFG = 12'h080;
  localparam logic [11:0] A_CFG_SH = 12'h0c0;

  // ==========================================================
  // Field positions
  localparam int CFG_DRIVE = 0;
  localparam int CFG_OE = 1;
  localparam int CFG_EV_EN = 2;
  localparam int CFG_EV_RISE = 3;
  localparam int TOP_PIN = 0;
  localparam int TOP_OVR = 1;
  localparam int TOP_OC = 2;
  localparam int TOP_EXT = 3;
  localparam int OC_CTRL_ON = 0;
  localparam int OC_CTRL_RUN = 1;
  localparam int COMMIT_REQ = 0;
  localparam int OVR_STATE_LSB = 16;
  localparam int THR_B_LSB = 8;
  localparam int SRC_FIELD = 8;

  // ==========================================================
  // Reset values
  localparam logic [DEB_W-1:0] RST_DEB = 16'h0010;
  localparam logic [THR_W-1:0] RST_THR = 8'h00;

endpackage

// ===== hw/spc_ocs_filter.sv
// Purpose: Debounce filter for one over-current comparator input.
// Assumes: The comparator output is asynchronous to pclk.
// Notes: Disabling the filter clears its level without a change pulse.
`timescale 1ns/1ps
`default_nettype none
module spc_ocs_filter
  import spc_pkg::*;
#(
  parameter int DW = DEB_W
)
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Comparator input and control.
  input wire logic sense_in,
  input wire logic enable,
  input wire logic [DW-1:0] deb_cycles,
  // Filtered result.
  output logic level_r,
  output logic changed_r,
  output logic running_r
);

  // ==========================================================
  // Synchroniser
  logic s1_r;
  logic s2_r;
  logic [DW-1:0] cnt_r;

  // Two flops before any logic looks at the pin.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
    end
    else
    begin
      s1_r <= sense_in;
      s2_r <= s1_r;
    end
  end

  // ==========================================================
  // Filter
  // A new level must hold for deb_cycles+1 clocks before it is taken.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_r <= '0;
      level_r <= 1'b0;
      changed_r <= 1'b0;
    end
    else if (!enable)
    begin
      cnt_r <= '0;
      level_r <= 1'b0;
      changed_r <= 1'b0;
    end
    else if (s2_r != level_r)
    begin
      if (cnt_r >= deb_cycles)
      begin
        cnt_r <= '0;
        level_r <= s2_r;
        changed_r <= 1'b1;
      end
      else
      begin
        cnt_r <= cnt_r + 1'b1;
        changed_r <= 1'b0;
      end
    end
    else
    begin
      cnt_r <= '0;
      changed_r <= 1'b0;
    end
  end

  // The running flag trails the enable by one clock.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      running_r <= 1'b0;
    else
      running_r <= enable;
  end

  a_level_change: assert property (
    @(posedge pclk) disable iff (!presetn)
    ($changed(level_r) && $past(enable)) |-> changed_r)
    else $error("Filtered level moved without a change pulse.");

endmodule // spc_ocs_filter
`default_nettype wire

// ===== verif/spc_load.sv
// Purpose: Loads on the programmable pins, seen from outside the block.
// Assumes: No pull resistors; an undriven pin shows the bench's level.
// Notes: The load never fights a pin that the block drives.
`timescale 1ns/1ps
`default_nettype none
module spc_load
(
  // Pins.
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe,
  input wire logic [15:0] ext_lvl,
  output logic [15:0] pin_in
);
  // A driven pin reads back its own value, else the outside level.
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule // spc_load
`default_nettype wire

// ===== verif/system_pio_interrupt_control_bench.sv
// Purpose: Self-checking bench of the pin and alert controller.
// Assumes: Zero-wait APB slave; registers at the package offsets.
// Notes: Table rows cover plain register traffic; events follow by hand.
`timescale 1ns/1ps
`default_nettype none
module system_pio_interrupt_control_bench;
  import spc_pkg::*;
  typedef struct packed {logic w; logic [11:0] a; logic [31:0] d;} spc_row_type;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sa, sb, an_out, an_oe, cmp_on;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic qe;
  logic [8:0] ext_flags;
  logic [15:0] pin_in, pin_out, pin_oe, ext_lvl;
  logic [7:0] thr_a, thr_b;
  int mismatches, n_compared, i;
  // A read row holds the expected word in its data field.
  spc_row_type rows [11] = '{
    '{1'b0, A_OC_DEB, 32'h10},
    '{1'b1, A_PIN_VEC, 32'ha5},
    '{1'b0, A_CFG, 32'h1},
    '{1'b0, A_CFG + 12'h004, 32'h0},
    '{1'b1, A_CFG + 12'h004, 32'h3},
    '{1'b0, A_PIN_VEC, 32'ha7},
    '{1'b1, A_TOP_FLAGS, 32'hffff},
    '{1'b0, A_TOP_FLAGS, 32'h0},
    '{1'b1, A_OC_THR, 32'h1234},
    '{1'b0, A_OC_THR, 32'h1234},
    '{1'b0, 12'h044, 32'h0}};
  spc_core #(.PIN_N(16), .EXT_W(9)) uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .ext_flags, .pin_in, .pin_out, .pin_oe,
    .overcurrent_sense_a(sa), .overcurrent_sense_b(sb), .overcurrent_threshold_a(thr_a),
    .overcurrent_threshold_b(thr_b), .overcurrent_compare_on(cmp_on), .alert_n_out(an_out),
    .alert_n_oe(an_oe));
  spc_load load (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext_lvl), .pin_in(pin_in));
  // ==========================================================
  // Helpers
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One transfer; an idle edge first so psel never changes twice at one edge.
  // Pready is read at the rising edge, before the design's flops move there.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
      mismatches++;
    q = prdata;
    qe = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task wrap_up;
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Free-running 40 MHz clock.
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // A hang well past the expected few hundred cycles ends the run.
  initial
  begin
    #2000000;
    mismatches++;
    wrap_up;
  end
  // ==========================================================
  // Main sequence
  initial
  begin
    {presetn, psel, penable, pwrite, sa, sb} = '0;
    {paddr, pwdata, ext_flags, ext_lvl} = '0;
    cyc(3);
    presetn <= 1'b1;
    chk(32'(an_oe), 32'h0);
    for (i = 0; i < 11; i++)
      if (rows[i].w)
        wr(rows[i].a, rows[i].d);
      else
        rd(rows[i].a, rows[i].d);
    // The last row reads a hole in the map and must be refused.
    chk(32'(qe), 32'h1);
    ext_lvl <= 16'h5a00;
    cyc(3);
    rd(A_PIN_LEVEL, 32'h5a02);
    wr(A_CFG + 12'h00c, 32'hc);
    wr(A_TOP_ENABLE, 32'h1);
    ext_lvl <= 16'h5a08;
    cyc(4);
    rd(A_PIN_FLAGS, 32'h8);
    chk(32'({an_oe, an_out}), 32'h2);
    wr(A_PIN_FLAGS, 32'h0);
    rd(A_PIN_FLAGS, 32'h8);
    wr(A_PIN_FLAGS, 32'h8);
    rd(A_PIN_FLAGS, 32'h0);
    cyc(3);
    chk(32'(an_oe), 32'h0);
    ext_flags <= 9'h001;
    cyc(3);
    wr(A_TOP_FLAGS, 32'h0);
    rd(A_TOP_FLAGS, 32'h8);
    ext_flags <= 9'h000;
    cyc(3);
    rd(A_TOP_FLAGS, 32'h0);
    // Shadow drive of pin 2 disagrees with the shadow vector on purpose.
    wr(A_CFG_SH + 12'h008, 32'h3);
    wr(A_PIN_VEC_SH, 32'h0);
    wr(A_COMMIT, 32'h1);
    rd(A_COMMIT, 32'h0);
    rd(A_CFG + 12'h008, 32'h3);
    rd(A_CFG + 12'h004, 32'h0);
    rd(A_PIN_VEC, 32'h4);
    // Override 3 watches pin 5 high and forces pins 0 and 1.
    wr(A_OVR_SRC, 32'h0500_0000);
    wr(A_OVR_WATCH, 32'h8);
    wr(A_OVR_MASK + 12'h00c, 32'h0001_0003);
    wr(A_TOP_ENABLE, 32'h2);
    wr(A_OVR_ARM, 32'h8);
    ext_lvl <= 16'h5a28;
    cyc(6);
    chk(32'({pin_oe[1:0], pin_out[1:0]}), 32'hd);
    rd(A_OVR_FLAGS, 32'h8);
    chk(32'(an_oe), 32'h1);
    wr(A_COMMIT, 32'h1);
    rd(A_COMMIT, 32'h1);
    wr(A_OVR_ARM, 32'h0);
    cyc(2);
    rd(A_COMMIT, 32'h0);
    wr(A_OVR_FLAGS, 32'h8);
    rd(A_OVR_FLAGS, 32'h0);
    // Over-current set-up in the required order, override 0 on sense a.
    wr(A_OC_CTRL, 32'h0);
    i = 0;
    do
    begin
      apb(1'b0, A_OC_CTRL, 32'h0);
      i++;
    end
    while (q[OC_CTRL_RUN] !== 1'b0 && i < 20);
    chk(32'(q[OC_CTRL_RUN]), 32'h0);
    // Pin 15 stands for the pin sharing a ball with sense b.
    wr(A_CFG + 12'h03c, 32'h0);
    wr(A_OC_DEB, 32'h3);
    wr(A_OC_INEN, 32'h1);
    wr(A_TOP_ENABLE, 32'h4);
    wr(A_OVR_SRC, 32'h0500_0010);
    wr(A_OVR_WATCH, 32'h1);
    wr(A_OVR_MASK, 32'h0000_0010);
    wr(A_OVR_ARM, 32'h1);
    wr(A_OC_CTRL, 32'h1);
    cyc(1);
    chk(32'({cmp_on, thr_b, thr_a}), 32'h11234);
    sa <= 1'b1;
    cyc(12);
    rd(A_OC_LEVEL, 32'h1);
    rd(A_OC_CHG, 32'h1);
    rd(A_TOP_FLAGS, 32'h6);
    chk(32'({an_oe, pin_oe[4]}), 32'h3);
    wr(A_OC_CHG, 32'h1);
    sa <= 1'b0;
    cyc(12);
    rd(A_OC_LEVEL, 32'h0);
    wr(A_OC_CTRL, 32'h0);
    cyc(2);
    chk(32'(cmp_on), 32'h0);
    // A second reset in mid-run drops the alert, the forced pins and setup.
    presetn <= 1'b0;
    cyc(2);
    chk(32'({an_oe, pin_oe, thr_a}), 32'h0);
    presetn <= 1'b1;
    rd(A_OC_THR, 32'h0);
    rd(A_OC_DEB, 32'h10);
    wrap_up;
  end
endmodule // system_pio_interrupt_control_bench
`default_nettype wire
